// *** src/drss_pkg.sv ***
package drss_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STOP_SPEED_OFS = 8'h04;
  localparam logic [7:0] STOP_TIME_OFS  = 8'h08;
  localparam logic [7:0] WAKE_DELAY_OFS = 8'h0c;
  localparam logic [7:0] START_FREQ_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;

  // Control register field positions
  localparam int CTRL_SW_RUN_BIT  = 0;
  localparam int CTRL_SRC_TERM    = 1;
  localparam int CTRL_SVC_BIT     = 2;
  localparam int CTRL_DET_SRC_BIT = 3;
  localparam int CTRL_GUARD_BIT   = 4;
  localparam int CTRL_ACT_LSB     = 5;
  localparam int CTRL_DIR_LSB     = 7;
  localparam int CTRL_SW_DIR_BIT  = 9;

  // Reset values, frequencies in 0.01 Hz, stop time in 0.01 s, wake delay in 0.1 s
  localparam logic [15:0] STOP_SPEED_RST = 16'h0032;
  localparam logic [15:0] STOP_SPEED_MAX = 16'h2710;
  localparam logic [15:0] STOP_TIME_RST  = 16'h0032;
  localparam logic [15:0] STOP_TIME_MAX  = 16'h2710;
  localparam logic [15:0] WAKE_DELAY_RST = 16'h0000;
  localparam logic [15:0] START_FREQ_RST = 16'h0000;
  localparam logic [1:0]  ACT_RST        = 2'h0;
  localparam logic [1:0]  DIR_MODE_RST   = 2'h0;

  // Below-limit actions and direction switching modes
  localparam logic [1:0] ACT_RUN_AT_LIMIT = 2'h0;
  localparam logic [1:0] ACT_STOP         = 2'h1;
  localparam logic [1:0] ACT_SLEEP        = 2'h2;
  localparam logic [1:0] DIR_AT_ZERO      = 2'h0;
  localparam logic [1:0] DIR_AT_START     = 2'h1;
  localparam logic [1:0] DIR_AT_STOP      = 2'h2;

  // Timing: base tick of 10 ms, wake tick of ten base ticks
  localparam int CLK_PERIOD_NS    = 50;
  localparam int TICK_MS          = 10;
  localparam int TICK_CYCLES_DFLT = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] WAKE_TICK_DIV = 4'ha;

  typedef struct packed {
    logic       sw_dir;
    logic [1:0] direction_switch_mode;
    logic [1:0] below_limit_action_sel;
    logic       powerup_terminal_run_guard;
    logic       stop_detect_source_sel;
    logic       svc_mode;
    logic       cmd_src_terminal;
    logic       sw_run;
  } drss_ctrl_s;

  typedef enum logic [2:0] {ST_INIT, ST_STOP, ST_RUN, ST_STANDBY, ST_PROTECT} drss_state_e;

endpackage : drss_pkg

// *** src/drss_hold_timer.sv ***
`timescale 1ns/100ps
module drss_hold_timer
  import drss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        cond,
  input  wire logic        tick,
  input  wire logic [15:0] limit,
  output logic             done
);

  logic [15:0] cnt_reg;
  logic        done_reg;

  // Any lapse of the condition restarts the count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!cond) begin
        cnt_reg <= 16'h0000;
      end else if (tick && cnt_reg < limit) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= cond && (cnt_reg >= limit);
    end
  end

  assign done = done_reg;

  a_timer_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !cond) |=> (cnt_reg == 16'h0000 && !done_reg))
    else $error("hold timer not cleared on lapse");

  a_timer_qualify: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(done_reg) |-> ($past(cond) && $past(cnt_reg) >= $past(limit)))
    else $error("hold timer done before the hold time");

endmodule : drss_hold_timer

// *** src/drss_supervisor.sv ***
`timescale 1ns/100ps
module drss_supervisor
  import drss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        run_terminal,
  input  wire logic        dir_terminal,
  input  wire logic [15:0] set_freq,
  input  wire logic [15:0] fb_freq,
  input  wire logic [15:0] lower_limit,
  output logic             drive_en,
  output logic      [15:0] freq_cmd,
  output logic             dir_out,
  output logic             standby,
  output logic             stop_reached,
  output logic             run_protected
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  drss_ctrl_s  ctrl_reg;
  logic [15:0] thr_reg;
  logic [15:0] stime_reg;
  logic [15:0] wake_reg;
  logic [15:0] start_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  drss_state_e state_reg;
  drss_state_e state_next;
  logic        drive_en_reg;
  logic [15:0] freq_cmd_reg;
  logic        dir_reg;
  logic        stop_done;
  logic        wake_done;
  logic        cfg_done_reg;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CTRL_OFS) || (a == STOP_SPEED_OFS) || (a == STOP_TIME_OFS) ||
                  (a == WAKE_DELAY_OFS) || (a == START_FREQ_OFS) || (a == STATUS_OFS);
  endfunction : addr_mapped

  // Out-of-range writes saturate instead of wrapping to a tiny value
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction : clamp

  logic acc_setup;
  logic acc_done;
  logic wr_en;
  assign acc_setup = psel && penable && !pready_reg;
  assign acc_done  = psel && penable && pready_reg;
  assign wr_en     = acc_done && pwrite && addr_mapped(paddr);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg  <= acc_setup;
      pslverr_reg <= acc_setup && !addr_mapped(paddr);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg  <= '{sw_dir: 1'b0, direction_switch_mode: DIR_MODE_RST, below_limit_action_sel: ACT_RST,
                     powerup_terminal_run_guard: 1'b0, stop_detect_source_sel: 1'b0, svc_mode: 1'b0,
                     cmd_src_terminal: 1'b0, sw_run: 1'b0};
      thr_reg   <= STOP_SPEED_RST;
      stime_reg <= STOP_TIME_RST;
      wake_reg  <= WAKE_DELAY_RST;
      start_reg <= START_FREQ_RST;
      cfg_done_reg <= 1'b0;
    end else if (clk_en && wr_en) begin
      case (paddr)
        CTRL_OFS: begin
          ctrl_reg     <= drss_ctrl_s'(pwdata[9:0]);
          cfg_done_reg <= 1'b1;
        end
        STOP_SPEED_OFS: thr_reg   <= clamp(pwdata[15:0], STOP_SPEED_MAX);
        STOP_TIME_OFS:  stime_reg <= clamp(pwdata[15:0], STOP_TIME_MAX);
        WAKE_DELAY_OFS: wake_reg  <= pwdata[15:0];
        START_FREQ_OFS: start_reg <= pwdata[15:0];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en && acc_setup) begin
      case (paddr)
        CTRL_OFS:       prdata_reg <= {22'h00_0000, ctrl_reg};
        STOP_SPEED_OFS: prdata_reg <= {16'h0000, thr_reg};
        STOP_TIME_OFS:  prdata_reg <= {16'h0000, stime_reg};
        WAKE_DELAY_OFS: prdata_reg <= {16'h0000, wake_reg};
        START_FREQ_OFS: prdata_reg <= {16'h0000, start_reg};
        STATUS_OFS:     prdata_reg <= {24'h00_0000, dir_reg, stop_done, drive_en_reg,
                                       (state_reg == ST_PROTECT), (state_reg == ST_STANDBY),
                                       3'(state_reg)};
        default:        prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base: 10 ms ticks for stop detection, 100 ms ticks for wake-up

  logic [31:0] tick_cnt_reg;
  logic [3:0]  deci_cnt_reg;
  logic        tick_10ms;
  logic        tick_100ms;
  assign tick_10ms  = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  assign tick_100ms = tick_10ms && (deci_cnt_reg == WAKE_TICK_DIV - 4'h1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      tick_cnt_reg <= tick_10ms ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      deci_cnt_reg <= 4'h0;
    end else if (clk_en && tick_10ms) begin
      deci_cnt_reg <= (deci_cnt_reg == WAKE_TICK_DIV - 4'h1) ? 4'h0 : deci_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop speed detection and wake qualification

  logic [15:0] det_speed;
  logic        below;
  logic        above;
  assign det_speed = (ctrl_reg.stop_detect_source_sel && !ctrl_reg.svc_mode) ? fb_freq : set_freq;
  assign below     = (lower_limit != 16'h0000) && (set_freq < lower_limit);
  assign above     = set_freq > lower_limit;

  drss_hold_timer u_stop_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .cond    (det_speed <= thr_reg),
    .tick    (tick_10ms),
    .limit   (stime_reg),
    .done    (stop_done)
  );

  drss_hold_timer u_wake_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .cond    (above),
    .tick    (tick_100ms),
    .limit   (wake_reg),
    .done    (wake_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Run supervision

  logic run_cmd;
  logic sleep_act;
  assign run_cmd   = ctrl_reg.cmd_src_terminal ? run_terminal : ctrl_reg.sw_run;
  assign sleep_act = (ctrl_reg.below_limit_action_sel == ACT_STOP) ||
                     (ctrl_reg.below_limit_action_sel == ACT_SLEEP);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: begin
        // Initialisation ends with the first control word; the terminal is sampled then, not before
        if (!cfg_done_reg) begin
          state_next = ST_INIT;
        end else if (ctrl_reg.cmd_src_terminal && run_terminal && !ctrl_reg.powerup_terminal_run_guard) begin
          state_next = ST_PROTECT;
        end else if (run_cmd) begin
          state_next = (below && sleep_act) ? ST_STANDBY : ST_RUN;
        end else begin
          state_next = ST_STOP;
        end
      end
      ST_PROTECT: begin
        if (!run_terminal || !ctrl_reg.cmd_src_terminal) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (run_cmd) begin
          state_next = (below && sleep_act) ? ST_STANDBY : ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_cmd) begin
          state_next = ST_STOP;
        end else if (below && sleep_act) begin
          state_next = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!run_cmd) begin
          state_next = ST_STOP;
        end else if (wake_done && !below) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_INIT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_INIT;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_en_reg <= 1'b0;
    end else if (clk_en) begin
      drive_en_reg <= (state_next == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction switching; a pending reversal forces zero speed so the ramp slows first

  logic dir_req;
  logic dir_ok;
  logic dir_pending;
  assign dir_req     = ctrl_reg.cmd_src_terminal ? dir_terminal : ctrl_reg.sw_dir;
  assign dir_pending = dir_req != dir_reg;

  always_comb begin
    case (ctrl_reg.direction_switch_mode)
      DIR_AT_ZERO:  dir_ok = (det_speed == 16'h0000);
      DIR_AT_START: dir_ok = (det_speed <= start_reg);
      DIR_AT_STOP:  dir_ok = stop_done;
      default:      dir_ok = (det_speed == 16'h0000);
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dir_reg <= 1'b0;
    end else if (clk_en && dir_pending && (dir_ok || state_reg != ST_RUN)) begin
      dir_reg <= dir_req;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      freq_cmd_reg <= 16'h0000;
    end else if (clk_en) begin
      if (state_next != ST_RUN || dir_pending) begin
        freq_cmd_reg <= 16'h0000;
      end else if (below && ctrl_reg.below_limit_action_sel == ACT_RUN_AT_LIMIT) begin
        freq_cmd_reg <= lower_limit;
      end else begin
        freq_cmd_reg <= set_freq;
      end
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign drive_en      = drive_en_reg;
  assign freq_cmd      = freq_cmd_reg;
  assign dir_out       = dir_reg;
  assign standby       = (state_reg == ST_STANDBY);
  assign stop_reached  = stop_done;
  assign run_protected = (state_reg == ST_PROTECT);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_init_term_run;
    state_reg == ST_INIT && clk_en && ctrl_reg.cmd_src_terminal && run_terminal;
  endsequence

  a_thr_reset:   assert property ($rose(rst_n) |-> thr_reg == STOP_SPEED_RST)
    else $error("stop threshold reset value wrong");
  a_stime_reset: assert property ($rose(rst_n) |-> stime_reg == STOP_TIME_RST && thr_reg <= STOP_SPEED_MAX)
    else $error("stop detect time reset value wrong");
  a_wake_reset:  assert property ($rose(rst_n) |-> wake_reg == WAKE_DELAY_RST)
    else $error("wake delay reset value wrong");
  a_src_select:  assert property ((!ctrl_reg.stop_detect_source_sel || ctrl_reg.svc_mode) |-> det_speed == set_freq)
    else $error("stop detection uses wrong speed");
  a_guard_src:   assert property ((state_reg == ST_INIT && clk_en && !ctrl_reg.cmd_src_terminal)
    |=> state_reg != ST_PROTECT)
    else $error("protection entered without terminal source");
  a_guard_hold:  assert property ((s_init_term_run and !ctrl_reg.powerup_terminal_run_guard)
    |=> (state_reg == ST_PROTECT && !drive_en_reg))
    else $error("protected run at power-on was not held off");
  a_guard_stay:  assert property ((state_reg == ST_PROTECT && clk_en && run_terminal && ctrl_reg.cmd_src_terminal)
    |=> state_reg == ST_PROTECT)
    else $error("protection left while command held");
  a_auto_start:  assert property ((s_init_term_run and ctrl_reg.powerup_terminal_run_guard)
    |=> (state_reg == ST_RUN || state_reg == ST_STANDBY))
    else $error("guarded start did not run after init");
  a_limit_run:   assert property ((clk_en && state_reg == ST_RUN && run_cmd && below && !dir_pending &&
    ctrl_reg.below_limit_action_sel == ACT_RUN_AT_LIMIT) |=> freq_cmd_reg == $past(lower_limit))
    else $error("not running at lower limit");
  a_coast_out:   assert property ((state_reg == ST_STANDBY) |-> (!drive_en_reg && freq_cmd_reg == 16'h0000))
    else $error("drive output present in standby");
  a_standby_go:  assert property ((clk_en && state_reg == ST_RUN && run_cmd && below && sleep_act)
    |=> state_reg == ST_STANDBY)
    else $error("standby not entered below limit");
  a_wake_gate:   assert property ((state_reg == ST_STANDBY ##1 state_reg == ST_RUN) |-> $past(wake_done))
    else $error("woke before delay elapsed");
  a_dir_change:  assert property ((clk_en && state_reg == ST_RUN && dir_pending && !dir_ok) |=> $stable(dir_reg))
    else $error("direction switched early");

endmodule : drss_supervisor

// *** tb/drss_motor_model.sv ***
`timescale 1ns/100ps
module drss_motor_model
  import drss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        term_cmd,
  input  wire logic [15:0] slip,
  input  wire logic        drive_en,
  input  wire logic [15:0] freq_cmd,
  output logic             run_terminal,
  output logic      [15:0] fb_freq
);
  logic [15:0] speed_reg;

  initial speed_reg = 16'h0000;

  ////////////////////////////////////////////////////////////////
  // Coasting sheds speed slowly, so feedback lags a removed output
  always_ff @(posedge sys_clk) begin
    if (drive_en) speed_reg <= freq_cmd;
    else if (speed_reg != 16'h0000) speed_reg <= speed_reg - 16'h0001;
  end

  assign fb_freq      = speed_reg + slip;
  assign run_terminal = term_cmd;
endmodule : drss_motor_model

// *** tb/drive_run_stop_supervisor_tb.sv ***
`timescale 1ns/100ps
module drive_run_stop_supervisor_tb
  import drss_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        clk_en  = 1'b1;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        term_cmd = 1'b1;
  logic [15:0] slip     = 16'h0;
  logic [15:0] set_freq = 16'h0;
  logic [15:0] lower_limit = 16'h0;
  logic        run_terminal, drive_en, dir_out, standby, stop_reached, run_protected;
  logic [15:0] fb_freq, freq_cmd;
  int          failures = 0;
  int          n_tests  = 0;

  always #25 sys_clk = ~sys_clk;

  // Short tick keeps the 10 ms and 100 ms timers within a few cycles
  drss_supervisor #(.TICK_CYCLES(4)) u_drss_supervisor (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_terminal(run_terminal), .dir_terminal(1'b0), .set_freq(set_freq),
    .fb_freq(fb_freq), .lower_limit(lower_limit), .drive_en(drive_en), .freq_cmd(freq_cmd),
    .dir_out(dir_out), .standby(standby), .stop_reached(stop_reached), .run_protected(run_protected));

  drss_motor_model u_drss_motor_model (
    .sys_clk(sys_clk), .term_cmd(term_cmd), .slip(slip), .drive_en(drive_en),
    .freq_cmd(freq_cmd), .run_terminal(run_terminal), .fb_freq(fb_freq));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) chk("pready", 1'b0, 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, q, exp);
    chk({what, "_err"}, e, exp_err);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Waits at most n cycles for the wanted drive state
  task automatic wait_drive(input logic want, input int n);
    int i;
    for (i = 0; i < n && drive_en !== want; i++) cyc(1);
  endtask : wait_drive

  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd("stop_speed", STOP_SPEED_OFS, 32'h32, 1'b0);
    rd("stop_time", STOP_TIME_OFS, 32'h32, 1'b0);
    rd("wake_delay", WAKE_DELAY_OFS, 32'h0, 1'b0);
    rd("ctrl", CTRL_OFS, 32'h0, 1'b0);
    rd("unmapped", 8'h40, 32'h0, 1'b1);
    wr(STOP_SPEED_OFS, 32'hffff);
    rd("stop_speed_sat", STOP_SPEED_OFS, 32'h2710, 1'b0);
    wr(STOP_SPEED_OFS, 32'h32);
    $display("t_regs done");
  endtask : t_regs

  task automatic do_reset;
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic t_powerup;
    // Terminal is high through power-on; software source must not be guarded
    chk("no_start", drive_en, 1'b0);
    set_freq <= 16'd2000;
    wr(CTRL_OFS, 32'h1);
    wait_drive(1'b1, 10);
    chk("no_guard", run_protected, 1'b0);
    chk("sw_src_run", drive_en, 1'b1);
    do_reset();
    wr(CTRL_OFS, 32'h2);
    cyc(3);
    chk("guarded", run_protected, 1'b1);
    chk("guard_off", drive_en, 1'b0);
    @(posedge sys_clk) term_cmd <= 1'b0;
    cyc(2);
    chk("guard_clear", run_protected, 1'b0);
    @(posedge sys_clk) term_cmd <= 1'b1;
    wait_drive(1'b1, 10);
    chk("term_rerun", drive_en, 1'b1);
    do_reset();
    wr(CTRL_OFS, 32'h12);
    wait_drive(1'b1, 10);
    chk("auto_start", drive_en, 1'b1);
    @(posedge sys_clk) term_cmd <= 1'b0;
    wait_drive(1'b0, 10);
    chk("term_stop", drive_en, 1'b0);
    wr(CTRL_OFS, 32'h1);
    wait_drive(1'b1, 10);
    chk("sw_run", freq_cmd, 16'd2000);
    $display("t_powerup done");
  endtask : t_powerup

  task automatic t_below;
    logic [1:0] act;
    @(posedge sys_clk) lower_limit <= 16'd1000;
    @(posedge sys_clk) set_freq <= 16'd500;
    cyc(3);
    chk("at_limit", freq_cmd, 16'd1000);
    chk("at_limit_run", drive_en, 1'b1);
    for (act = ACT_STOP; act <= ACT_SLEEP; act++) begin
      wr(CTRL_OFS, {act, 5'h1});
      wait_drive(1'b0, 10);
      chk("coast", drive_en, 1'b0);
      chk("standby", standby, 1'b1);
      @(posedge sys_clk) set_freq <= 16'd2000;
      wait_drive(1'b1, 10);
      chk("wake_now", drive_en, 1'b1);
      @(posedge sys_clk) set_freq <= 16'd500;
    end
    $display("t_below done");
  endtask : t_below

  task automatic t_wake;
    wr(WAKE_DELAY_OFS, 32'h3);
    cyc(5);
    chk("asleep", standby, 1'b1);
    @(posedge sys_clk) set_freq <= 16'd2000;
    cyc(70);
    chk("early", drive_en, 1'b0);
    @(posedge sys_clk) set_freq <= 16'd1000;
    @(posedge sys_clk) set_freq <= 16'd2000;
    cyc(70);
    chk("restart", drive_en, 1'b0);
    wait_drive(1'b1, 100);
    chk("woke", drive_en, 1'b1);
    @(posedge sys_clk) lower_limit <= 16'd0;
    @(posedge sys_clk) set_freq <= 16'd30;
    cyc(5);
    chk("limit_zero", drive_en, 1'b1);
    $display("t_wake done");
  endtask : t_wake

  task automatic t_stop;
    int i;
    wr(STOP_TIME_OFS, 32'h5);
    @(posedge sys_clk) set_freq <= 16'd2000;
    cyc(2);
    chk("not_yet", stop_reached, 1'b0);
    @(posedge sys_clk) set_freq <= 16'd30;
    for (i = 0; i < 40 && stop_reached !== 1'b1; i++) cyc(1);
    chk("reached", stop_reached, 1'b1);
    chk("held_min", i > 14, 1'b1);
    @(posedge sys_clk) slip <= 16'd1000;
    cyc(10);
    chk("set_src", stop_reached, 1'b1);
    wr(CTRL_OFS, 32'h9);
    cyc(5);
    chk("fb_src", stop_reached, 1'b0);
    $display("t_stop done");
  endtask : t_stop

  task automatic t_dir;
    @(posedge sys_clk) slip <= 16'd0;
    wr(CTRL_OFS, 32'h201);
    cyc(5);
    chk("dir_hold", dir_out, 1'b0);
    chk("dir_zero_cmd", freq_cmd, 16'd0);
    @(posedge sys_clk) set_freq <= 16'd0;
    cyc(3);
    chk("dir_switch", dir_out, 1'b1);
    $display("t_dir done");
  endtask : t_dir

  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(3);
    t_regs();
    t_powerup();
    t_below();
    t_wake();
    t_stop();
    t_dir();
    end_of_test();
  end

  // The tests take about 340 cycles
  initial begin
    #(20000 * 50);
    failures++;
    end_of_test();
  end
endmodule : drive_run_stop_supervisor_tb
